// file: gple_level_pwm_encoder.sv
// How it works
// - Two-bit selector picks 16, 64, 256 or 1024 clocks per time-base tick.
// - Selected time base clocks the pattern engine whether or not the pin drives out.
// - Low logical output value drives the pin with the low-level pattern.
// - High phase lasts high count times the time base.
// - Low phase lasts low count times the time base.
// - Period is sum of both counts times time base, repeating endlessly.
// - High count zero, low count nonzero: pin held static low.
// - Low count zero, high count nonzero: pin held static high.
// - Both counts zero: pin held static low.
// - Low-level config word at index 51h, resets to 007Fh, static low.
// - Index 52h holds high-level pattern counts, same zero-count behaviour.
`timescale 1ns/1ps
`default_nettype none
module gple_level_pwm_encoder (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic coreClkEn,
    input wire gple_pkg::gple_axi_req_t axiReq,
    output gple_pkg::gple_axi_rsp_t axiRsp,
    output logic ioPinOne,
    output logic ioPinOneOe
);
    // ==========================================================
    // Registers
    logic [gple_pkg::REG_W-1:0] pin_one_low_level_pattern_config;
    logic [gple_pkg::REG_W-1:0] pin_one_high_level_pattern_config;
    logic [gple_pkg::REG_W-1:0] pinControl;
    logic [gple_pkg::REG_W-1:0] pinStatus;

    // ==========================================================
    // Bus slave state
    logic awReady;
    logic awHeld;
    logic [gple_pkg::AXI_AW-1:0] awAddrHeld;
    logic wReady;
    logic wHeld;
    logic [gple_pkg::AXI_DW-1:0] wDataHeld;
    logic [gple_pkg::AXI_DW/8-1:0] wStrbHeld;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [gple_pkg::AXI_DW-1:0] rData;
    logic doWrite;
    logic [gple_pkg::AXI_AW-1:0] wrWord;
    logic [gple_pkg::AXI_AW-1:0] rdWord;
    logic wrLowCfg;
    logic wrHighCfg;
    logic wrCtrl;
    logic wrMapped;

    // ==========================================================
    // Pattern selection and pin state
    logic logicValue;
    logic prevValue;
    logic primed;
    logic engineRestart;
    gple_pkg::gple_pattern_t lowPattern;
    gple_pkg::gple_pattern_t highPattern;
    gple_pkg::gple_pattern_t activePattern;
    logic engineLevel;
    logic engineHigh;
    logic engineStatic;

    assign axiRsp.awready = awReady;
    assign axiRsp.wready = wReady;
    assign axiRsp.bresp = bResp;
    assign axiRsp.bvalid = bValid;
    assign axiRsp.arready = arReady;
    assign axiRsp.rdata = rData;
    assign axiRsp.rresp = rResp;
    assign axiRsp.rvalid = rValid;

    // ==========================================================
    // Write address channel
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            awReady <= 1'b0;
            awHeld <= 1'b0;
            awAddrHeld <= '0;
        end else if (coreClkEn) begin
            if (awReady && axiReq.awvalid) begin
                awReady <= 1'b0;
                awHeld <= 1'b1;
                awAddrHeld <= axiReq.awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end else if (!awHeld && !bValid) begin
                awReady <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Write data channel
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wReady <= 1'b0;
            wHeld <= 1'b0;
            wDataHeld <= '0;
            wStrbHeld <= '0;
        end else if (coreClkEn) begin
            if (wReady && axiReq.wvalid) begin
                wReady <= 1'b0;
                wHeld <= 1'b1;
                wDataHeld <= axiReq.wdata;
                wStrbHeld <= axiReq.wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end else if (!wHeld && !bValid) begin
                wReady <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Write decode
    assign doWrite = awHeld & wHeld & ~bValid;
    assign wrWord = {awAddrHeld[gple_pkg::AXI_AW-1:2], 2'h0};
    assign wrLowCfg = doWrite & (wrWord == gple_pkg::ADDR_LOW_CFG);
    assign wrHighCfg = doWrite & (wrWord == gple_pkg::ADDR_HIGH_CFG);
    assign wrCtrl = doWrite & (wrWord == gple_pkg::ADDR_CTRL);
    // Status accepts writes and ignores them rather than erroring
    assign wrMapped = (wrWord == gple_pkg::ADDR_LOW_CFG) |
        (wrWord == gple_pkg::ADDR_HIGH_CFG) |
        (wrWord == gple_pkg::ADDR_CTRL) |
        (wrWord == gple_pkg::ADDR_STATUS);

    // ==========================================================
    // Write response channel
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bValid <= 1'b0;
            bResp <= gple_pkg::RESP_OKAY;
        end else if (coreClkEn) begin
            if (doWrite) begin
                bValid <= 1'b1;
                bResp <= wrMapped ? gple_pkg::RESP_OKAY :
                    gple_pkg::RESP_SLVERR;
            end else if (bValid && axiReq.bready) begin
                bValid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Low-level pattern config word
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_one_low_level_pattern_config <= gple_pkg::LOW_CFG_RST;
        end else if (coreClkEn && wrLowCfg) begin
            if (wStrbHeld[0]) begin
                pin_one_low_level_pattern_config[7:0] <= wDataHeld[7:0];
            end
            if (wStrbHeld[1]) begin
                pin_one_low_level_pattern_config[15:8] <= wDataHeld[15:8];
            end
        end
    end

    // ==========================================================
    // High-level pattern config word; top two bits reserved
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_one_high_level_pattern_config <= gple_pkg::HIGH_CFG_RST;
        end else if (coreClkEn && wrHighCfg) begin
            if (wStrbHeld[0]) begin
                pin_one_high_level_pattern_config[7:0] <= wDataHeld[7:0];
            end
            if (wStrbHeld[1]) begin
                pin_one_high_level_pattern_config[15:8] <=
                    wDataHeld[15:8] & gple_pkg::HIGH_CFG_MASK[15:8];
            end
        end
    end

    // ==========================================================
    // Pin control: logical value and direction
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pinControl <= gple_pkg::CTRL_RST;
        end else if (coreClkEn && wrCtrl && wStrbHeld[0]) begin
            pinControl[gple_pkg::CTRL_VALUE_BIT] <=
                wDataHeld[gple_pkg::CTRL_VALUE_BIT];
            pinControl[gple_pkg::CTRL_OUTPUT_BIT] <=
                wDataHeld[gple_pkg::CTRL_OUTPUT_BIT];
        end
    end

    // ==========================================================
    // Status view of the live waveform
    always_comb begin
        pinStatus = '0;
        pinStatus[gple_pkg::STAT_LEVEL_BIT] = engineLevel;
        pinStatus[gple_pkg::STAT_HIGHPH_BIT] = engineHigh;
        pinStatus[gple_pkg::STAT_STATIC_BIT] = engineStatic;
        pinStatus[gple_pkg::STAT_VALUE_BIT] = logicValue;
    end

    // ==========================================================
    // Read channel
    assign rdWord = {axiReq.araddr[gple_pkg::AXI_AW-1:2], 2'h0};

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            arReady <= 1'b0;
        end else if (coreClkEn) begin
            if (arReady && axiReq.arvalid) begin
                arReady <= 1'b0;
            end else if (!rValid && !arReady) begin
                arReady <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rValid <= 1'b0;
            rResp <= gple_pkg::RESP_OKAY;
            rData <= '0;
        end else if (coreClkEn) begin
            if (arReady && axiReq.arvalid) begin
                rValid <= 1'b1;
                rResp <= gple_pkg::RESP_OKAY;
                rData <= '0;
                case (rdWord)
                    gple_pkg::ADDR_LOW_CFG: begin
                        rData[15:0] <= pin_one_low_level_pattern_config;
                    end
                    gple_pkg::ADDR_HIGH_CFG: begin
                        rData[15:0] <= pin_one_high_level_pattern_config;
                    end
                    gple_pkg::ADDR_CTRL: begin
                        rData[15:0] <= pinControl;
                    end
                    gple_pkg::ADDR_STATUS: begin
                        rData[15:0] <= pinStatus;
                    end
                    default: begin
                        rResp <= gple_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (rValid && axiReq.rready) begin
                rValid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Pattern selection by logical output value
    assign logicValue = pinControl[gple_pkg::CTRL_VALUE_BIT];
    assign lowPattern =
        gple_pkg::gple_pattern_t'(pin_one_low_level_pattern_config);

    always_comb begin
        highPattern =
            gple_pkg::gple_pattern_t'(pin_one_high_level_pattern_config);
        // Only the low-level word carries a time base; both share it
        highPattern.timeBase = lowPattern.timeBase;
    end

    assign activePattern = logicValue ? highPattern : lowPattern;

    // A level change restarts at once; waiting for the period end
    // could delay a plain data change by up to 254 ticks
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prevValue <= 1'b0;
            primed <= 1'b0;
        end else if (coreClkEn) begin
            prevValue <= logicValue;
            primed <= 1'b1;
        end
    end

    assign engineRestart = ~primed | (logicValue ^ prevValue);

    gple_pattern_engine patternEngine (
        .core_clk(core_clk),
        .resetn(resetn),
        .coreClkEn(coreClkEn),
        .restart(engineRestart),
        .cfg(activePattern),
        .level(engineLevel),
        .highPhase(engineHigh),
        .staticMode(engineStatic)
    );

    // ==========================================================
    // Pin driver; pattern reaches the pin only as an output
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ioPinOne <= 1'b0;
            ioPinOneOe <= 1'b0;
        end else if (coreClkEn) begin
            ioPinOneOe <= pinControl[gple_pkg::CTRL_OUTPUT_BIT];
            ioPinOne <= pinControl[gple_pkg::CTRL_OUTPUT_BIT] &
                engineLevel;
        end
    end
endmodule
`default_nettype wire

// file: gple_pkg.sv
`default_nettype none
package gple_pkg;
    // ==========================================================
    // Bus widths and answers
    localparam int unsigned AXI_AW = 12;
    localparam int unsigned AXI_DW = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LOW_CFG = 8'h51;
    localparam logic [7:0] IDX_HIGH_CFG = 8'h52;
    localparam logic [7:0] IDX_CTRL = 8'h60;
    localparam logic [7:0] IDX_STATUS = 8'h61;
    localparam logic [AXI_AW-1:0] ADDR_LOW_CFG = {2'h0, IDX_LOW_CFG, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_HIGH_CFG = {2'h0, IDX_HIGH_CFG, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [AXI_AW-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // ==========================================================
    // Field layout and reset values
    localparam int unsigned REG_W = 16;
    localparam int unsigned CNT_W = 7;
    localparam int unsigned TB_W = 2;
    localparam int unsigned TB_LSB = 14;
    localparam int unsigned HC_LSB = 7;
    localparam int unsigned LC_LSB = 0;
    localparam logic [REG_W-1:0] LOW_CFG_RST = 16'h007f;
    localparam logic [REG_W-1:0] HIGH_CFG_RST = 16'h3f80;
    localparam logic [REG_W-1:0] HIGH_CFG_MASK = 16'h3fff;
    localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
    localparam int unsigned CTRL_VALUE_BIT = 0;
    localparam int unsigned CTRL_OUTPUT_BIT = 1;
    localparam int unsigned STAT_LEVEL_BIT = 0;
    localparam int unsigned STAT_HIGHPH_BIT = 1;
    localparam int unsigned STAT_STATIC_BIT = 2;
    localparam int unsigned STAT_VALUE_BIT = 3;

    // ==========================================================
    // Time base: last prescaler count for 16, 64, 256, 1024 clocks
    localparam int unsigned PRE_W = 10;
    localparam logic [PRE_W-1:0] TB_LAST_16 = 10'h00f;
    localparam logic [PRE_W-1:0] TB_LAST_64 = 10'h03f;
    localparam logic [PRE_W-1:0] TB_LAST_256 = 10'h0ff;
    localparam logic [PRE_W-1:0] TB_LAST_1024 = 10'h3ff;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [TB_W-1:0] timeBase;
        logic [CNT_W-1:0] highCount;
        logic [CNT_W-1:0] lowCount;
    } gple_pattern_t;

    typedef enum logic [1:0] {ST_STATIC, ST_HIGH, ST_LOW} gple_phase_t;

    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic awvalid;
        logic [AXI_DW-1:0] wdata;
        logic [AXI_DW/8-1:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AXI_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } gple_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [AXI_DW-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } gple_axi_rsp_t;
endpackage
`default_nettype wire

// file: gple_pattern_engine.sv
`timescale 1ns/1ps
`default_nettype none
module gple_pattern_engine (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic coreClkEn,
    input wire logic restart,
    input wire gple_pkg::gple_pattern_t cfg,
    output logic level,
    output logic highPhase,
    output logic staticMode
);
    // ==========================================================
    // Held pattern and counters
    gple_pkg::gple_pattern_t held;
    gple_pkg::gple_phase_t state;
    logic [gple_pkg::PRE_W-1:0] preCnt;
    logic [gple_pkg::PRE_W-1:0] preLast;
    logic [gple_pkg::CNT_W-1:0] phaseCnt;
    logic tick;
    logic boundary;

    always_comb begin
        case (held.timeBase)
            2'h0: preLast = gple_pkg::TB_LAST_16;
            2'h1: preLast = gple_pkg::TB_LAST_64;
            2'h2: preLast = gple_pkg::TB_LAST_256;
            default: preLast = gple_pkg::TB_LAST_1024;
        endcase
    end

    assign tick = (preCnt == preLast);
    // New settings are taken only here, so only a restart cuts a phase short
    assign boundary = restart | (tick & ((state == gple_pkg::ST_STATIC) |
        ((state == gple_pkg::ST_LOW) & (phaseCnt == '0))));
    assign highPhase = (state == gple_pkg::ST_HIGH);
    assign staticMode = (state == gple_pkg::ST_STATIC);

    // ==========================================================
    // Prescaler
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            preCnt <= '0;
        end else if (coreClkEn) begin
            if (boundary || tick) begin
                preCnt <= '0;
            end else begin
                preCnt <= preCnt + 10'h001;
            end
        end
    end

    // ==========================================================
    // Pattern taken at the period boundary
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            held <= gple_pkg::gple_pattern_t'(gple_pkg::LOW_CFG_RST);
        end else if (coreClkEn && boundary) begin
            held <= cfg;
        end
    end

    // ==========================================================
    // Phase sequencer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= gple_pkg::ST_STATIC;
            phaseCnt <= '0;
            level <= 1'b0;
        end else if (coreClkEn) begin
            if (boundary) begin
                if (cfg.highCount == '0) begin
                    state <= gple_pkg::ST_STATIC;
                    level <= 1'b0;
                    phaseCnt <= '0;
                end else if (cfg.lowCount == '0) begin
                    state <= gple_pkg::ST_STATIC;
                    level <= 1'b1;
                    phaseCnt <= '0;
                end else begin
                    state <= gple_pkg::ST_HIGH;
                    level <= 1'b1;
                    phaseCnt <= cfg.highCount - 7'h01;
                end
            end else if (tick) begin
                case (state)
                    gple_pkg::ST_HIGH: begin
                        if (phaseCnt == '0) begin
                            state <= gple_pkg::ST_LOW;
                            level <= 1'b0;
                            phaseCnt <= held.lowCount - 7'h01;
                        end else begin
                            phaseCnt <= phaseCnt - 7'h01;
                        end
                    end
                    gple_pkg::ST_LOW: begin
                        phaseCnt <= phaseCnt - 7'h01;
                    end
                    default: begin
                        phaseCnt <= phaseCnt;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: gple_level_pwm_encoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module gple_level_pwm_encoder_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic coreClkEn,
    input wire gple_pkg::gple_axi_req_t axiReq,
    input wire gple_pkg::gple_axi_rsp_t axiRsp,
    input wire logic ioPinOne,
    input wire logic ioPinOneOe
);
    logic [19:0] runCnt;
    logic cleanRun;
    logic pinPrev;
    logic [3:0] dirtyHist;
    logic wrBoth;
    logic arHs;
    logic arMapped;
    logic awMapped;
    logic ctrlWrite;
    assign wrBoth = coreClkEn && axiReq.awvalid && axiRsp.awready
        && axiReq.wvalid && axiRsp.wready;
    assign arHs = coreClkEn && axiReq.arvalid && axiRsp.arready;
    assign arMapped = axiReq.araddr inside {gple_pkg::ADDR_LOW_CFG,
        gple_pkg::ADDR_HIGH_CFG, gple_pkg::ADDR_CTRL, gple_pkg::ADDR_STATUS};
    assign awMapped = axiReq.awaddr inside {gple_pkg::ADDR_LOW_CFG,
        gple_pkg::ADDR_HIGH_CFG, gple_pkg::ADDR_CTRL, gple_pkg::ADDR_STATUS};
    assign ctrlWrite = coreClkEn && axiReq.awvalid && axiRsp.awready
        && axiReq.awaddr == gple_pkg::ADDR_CTRL;

    // ==========================================================
    // Runs near a CTRL write or an OE change are not judged
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            runCnt <= 20'h0;
            cleanRun <= 1'b0;
            pinPrev <= 1'b0;
            dirtyHist <= 4'hf;
        end else begin
            pinPrev <= ioPinOne;
            dirtyHist <= {dirtyHist[2:0], ctrlWrite || !ioPinOneOe};
            if (ioPinOne != pinPrev) begin
                runCnt <= 20'h1;
                cleanRun <= ioPinOneOe && !ctrlWrite && dirtyHist == 4'h0;
            end else begin
                runCnt <= runCnt + 20'h1;
                if (ctrlWrite || !ioPinOneOe) begin
                    cleanRun <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    run_grid_a: assert property (
        (ioPinOne != pinPrev) && cleanRun
            |-> runCnt[3:0] == 4'h0 && runCnt != 20'h0)
        else $error("run off tick grid");
    pin_quiet_a: assert property (
        !ioPinOneOe |-> !ioPinOne)
        else $error("pin high undriven");
    oe_follow_a: assert property (
        wrBoth && axiReq.awaddr == gple_pkg::ADDR_CTRL && axiReq.wstrb[0]
            |-> ##3 ioPinOneOe == $past(axiReq.wdata[1], 3))
        else $error("oe not following");
    wr_answer_a: assert property (
        wrBoth |=> ##1 axiRsp.bvalid
            && ((axiRsp.bresp == gple_pkg::RESP_OKAY) == $past(awMapped, 2)))
        else $error("bad write answer");
    rd_answer_a: assert property (
        arHs |=> axiRsp.rvalid
            && ((axiRsp.rresp == gple_pkg::RESP_OKAY) == $past(arMapped)))
        else $error("bad read answer");
    unmapped_zero_a: assert property (
        axiRsp.rvalid && axiRsp.rresp == gple_pkg::RESP_SLVERR
            |-> axiRsp.rdata == 32'h0)
        else $error("error data not zero");
    upper_zero_a: assert property (
        axiRsp.rvalid |-> axiRsp.rdata[31:16] == 16'h0)
        else $error("upper half set");
    one_read_a: assert property (
        axiRsp.rvalid |-> !axiRsp.arready)
        else $error("read taken in answer");
    hicfg_rsvd_a: assert property (
        arHs && axiReq.araddr == gple_pkg::ADDR_HIGH_CFG
            |=> axiRsp.rdata[15:14] == 2'h0)
        else $error("reserved bits set");
endmodule

bind gple_level_pwm_encoder gple_level_pwm_encoder_sva
    gple_level_pwm_encoder_sva_i (.core_clk(core_clk), .resetn(resetn),
    .coreClkEn(coreClkEn), .axiReq(axiReq), .axiRsp(axiRsp),
    .ioPinOne(ioPinOne), .ioPinOneOe(ioPinOneOe));
`default_nettype wire

// file: gple_pin_probe.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side receiver of pin runs
module gple_pin_probe (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic pin,
    input wire logic pinOe,
    output logic runValid,
    output logic runHigh,
    output logic [19:0] runLen
);
    logic lastPin;
    logic [19:0] count;
    // Runs cut by release are dropped
    always_ff @(posedge core_clk) begin
        runValid <= 1'b0;
        if (!resetn || !pinOe) begin
            lastPin <= pin;
            count <= 20'h1;
        end else if (pin != lastPin) begin
            runValid <= 1'b1;
            runHigh <= lastPin;
            runLen <= count;
            count <= 20'h1;
            lastPin <= pin;
        end else begin
            count <= count + 20'h1;
        end
    end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Encoder bench
module testbench;
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } gple_tb_rd_t;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic coreClkEn = 1'b1;
    gple_pkg::gple_axi_req_t axiReq = '0;
    gple_pkg::gple_axi_rsp_t axiRsp;
    logic ioPinOne;
    logic ioPinOneOe;
    logic runValid;
    logic runHigh;
    logic [19:0] runLen;
    int n_mismatch = 0;
    int n_tests = 0;
    int skipRuns = 0;
    gple_tb_rd_t rdQ[$];
    logic [1:0] wrQ[$];
    logic [20:0] runQ[$];
    logic [6:0] hc;
    logic [6:0] lc;
    logic [31:0] d;
    logic [6:0] sH[3] = '{7'h00, 7'h05, 7'h00};
    logic [6:0] sL[3] = '{7'h05, 7'h00, 7'h00};
    logic sLvl[3] = '{1'b0, 1'b1, 1'b0};
    localparam logic [1:0] OK = gple_pkg::RESP_OKAY;
    localparam logic [31:0] ALL = 32'hffffffff;
    localparam logic [11:0] LO = gple_pkg::ADDR_LOW_CFG;
    localparam logic [11:0] HI = gple_pkg::ADDR_HIGH_CFG;
    localparam logic [11:0] CT = gple_pkg::ADDR_CTRL;
    localparam logic [11:0] ST = gple_pkg::ADDR_STATUS;

    always #12.5 core_clk = ~core_clk;

    gple_level_pwm_encoder gple_level_pwm_encoder_i (
        .core_clk(core_clk), .resetn(resetn), .coreClkEn(coreClkEn),
        .axiReq(axiReq), .axiRsp(axiRsp),
        .ioPinOne(ioPinOne), .ioPinOneOe(ioPinOneOe));
    gple_pin_probe gple_pin_probe_i (
        .core_clk(core_clk), .resetn(resetn), .pin(ioPinOne),
        .pinOe(ioPinOneOe), .runValid(runValid), .runHigh(runHigh),
        .runLen(runLen));

    // ==========================================================
    // Compare and bus tasks
    task automatic bad(input logic [31:0] g, logic [31:0] e);
        n_mismatch++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic chkWord(input logic [31:0] g, logic [31:0] e);
        n_tests++;
        if (g !== e) bad(g, e);
    endtask
    task automatic chkResp(input logic [1:0] g, logic [1:0] e);
        n_tests++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask
    task automatic chkRun(input logic [19:0] g, logic [19:0] e);
        n_tests++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask
    function logic [31:0] pat(input logic [1:0] tb, logic [6:0] h,
        logic [6:0] l);
        return {16'h0000, tb, h, l};
    endfunction
    task wr(input logic [11:0] a, logic [31:0] v, logic [3:0] s,
        logic [1:0] r);
        @(posedge core_clk);
        wrQ.push_back(r);
        axiReq.awaddr <= a;
        axiReq.wdata <= v;
        axiReq.wstrb <= s;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (!axiRsp.bvalid);
        axiReq.bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a, logic [31:0] e, logic [31:0] m,
        logic [1:0] r);
        @(posedge core_clk);
        rdQ.push_back('{e, m, r});
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (!axiRsp.rvalid);
        axiReq.rready <= 1'b0;
    endtask
    task runs(input int hi, int lo);
        skipRuns = 2;
        runQ.push_back({1'b1, 20'(hi)});
        runQ.push_back({1'b0, 20'(lo)});
        while (runQ.size() > 0) @(posedge core_clk);
    endtask
    task test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Result watcher
    always @(posedge core_clk) begin
        if (axiRsp.rvalid && axiReq.rready && rdQ.size() > 0) begin
            chkWord(axiRsp.rdata & rdQ[0].m, rdQ[0].d);
            chkResp(axiRsp.rresp, rdQ[0].r);
            rdQ.delete(0);
        end
        if (axiRsp.bvalid && axiReq.bready && wrQ.size() > 0) begin
            chkResp(axiRsp.bresp, wrQ[0]);
            wrQ.delete(0);
        end
        if (runValid) begin
            if (skipRuns > 0) skipRuns--;
            else if (runQ.size() > 0 && runHigh === runQ[0][20]) begin
                chkRun(runLen, runQ[0][19:0]);
                runQ.delete(0);
            end
        end
    end

    initial begin
        repeat (90000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h36e9));
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd(LO, 32'h007f, ALL, OK);
        rd(HI, 32'h3f80, ALL, OK);
        rd(CT, 32'h0, ALL, OK);
        rd(ST, 32'h4, 32'hd, OK);
        rd(12'h000, 32'h0, ALL, gple_pkg::RESP_SLVERR);
        wr(12'h004, 32'hffff, 4'hf, gple_pkg::RESP_SLVERR);
        d = $urandom;
        wr(HI, d, 4'hf, OK);
        rd(HI, {18'h0, d[13:0]}, ALL, OK);
        wr(LO, 32'hffff, 4'h1, OK);
        rd(LO, 32'h00ff, ALL, OK);
        wr(CT, 32'h2, 4'hf, OK);
        for (int tb = 0; tb < 4; tb++) begin
            hc = (tb == 0) ? 7'(1 + $urandom % 7) : 7'h01;
            lc = (tb == 0) ? 7'(1 + $urandom % 7) : 7'h02;
            wr(LO, pat(2'(tb), hc, lc), 4'hf, OK);
            runs(hc * (16 << (2 * tb)), lc * (16 << (2 * tb)));
        end
        wr(LO, pat(2'h0, 7'h7f, 7'h01), 4'hf, OK);
        runs(2032, 16);
        wr(HI, pat(2'h3, 7'h02, 7'h03), 4'hf, OK);
        wr(CT, 32'h3, 4'hf, OK);
        runs(32, 48);
        wr(CT, 32'h2, 4'hf, OK);
        for (int i = 0; i < 3; i++) begin
            wr(LO, pat(2'h0, sH[i], sL[i]), 4'hf, OK);
            repeat (4200) @(posedge core_clk);
            rd(ST, {29'h0, 2'h2, sLvl[i]}, 32'h5, OK);
            chkWord(32'(ioPinOne), 32'(sLvl[i]));
        end
        test_done();
    end
endmodule
`default_nettype wire
